// *** tsic_pkg.sv ***
// Operation
// - Twenty request sources: five timers, three pins, converter, pulse unit, serial, six units, base, touch, comparator
// - Each source has its own priority bit selecting high or low level
// - Each external pin triggers on rising, falling or both edges, set per pin
// - Each source owns a request flag, enable bit, priority bit and vector
// - Global enable clear blocks every source regardless of its own enable
// - Pin 0 vectors to 0003H, polled first, auto-cleared on service, wakes from stop
// - Pin 1 vectors to 0013H, polled third, auto-cleared, wakes from stop
// - Serial 0023H, units 0-3 at 003BH/007BH/0083H/008BH, software clears, no wake
// - Converter vectors 0033H, polled seventh, software clears, no stop wake
// - Base tick vectors 004BH, polled tenth, auto-cleared, wakes from stop
// - Pin 2 vectors 0053H, polled eleventh, no visible flag, wakes from stop
// - Touch overflow vectors 005BH, polled twelfth, auto-cleared, no stop wake
// - Comparator vectors 0063H, polled thirteenth, software clears, wakes from stop
// - Equal priority: lower vector wins; high priority pre-empts running low handler
// - On acceptance CPU finishes instruction, saves PC, loads vector; return restores
package tsic_pkg;
  localparam int NUM_SRC = 20;
  localparam int IDX_W = 5;
  // Source index equals polling place minus one
  localparam int EXT0_IDX = 0;
  localparam int EXT1_IDX = 2;
  localparam int EXT2_IDX = 10;
  localparam logic [19:0] EXT_SRC_MASK = 20'h00405;
  // Flags cleared by hardware when the vector is taken
  localparam logic [19:0] HW_CLEAR_MASK = 20'h00e0f;
  // Sources able to wake the core from stop
  localparam logic [19:0] WAKE_MASK = 20'h01605;
  // Pin 2 has no software-visible flag
  localparam logic [19:0] VISIBLE_MASK = 20'hffbff;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] PRIO_OFS = 8'h08;
  localparam logic [7:0] FLAG_OFS = 8'h0c;
  localparam logic [7:0] EXTCFG_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // Edge mode per pin: 00 falling, 01 rising, 1x both
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [5:0] EXTCFG_RST = 6'h00;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [19:0] ENABLE_RST = 20'h00000;
  localparam logic [19:0] PRIO_RST = 20'h00000;
  localparam logic [19:0] FLAG_RST = 20'h00000;
endpackage : tsic_pkg

// *** tsic_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsic_controller (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Peripheral request pulses, pin positions ignored
  input wire logic [19:0] periph_req_i,
  input wire logic [2:0] ext_pin_irq_i,
  // CPU side
  input wire logic cpu_ack_i,
  input wire logic cpu_reti_i,
  output logic cpu_irq_o,
  output logic [15:0] cpu_vector_o,
  output logic stop_wake_o
);

  function automatic logic [5:0] first_set(input logic [19:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = tsic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[4:0]};
      end
    end
    return r;
  endfunction : first_set

  function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
    logic r;
    r = 1'b0;
    if (mode == tsic_pkg::EDGE_FALL) begin
      r = prev & ~cur;
    end else if (mode == tsic_pkg::EDGE_RISE) begin
      r = ~prev & cur;
    end else begin
      r = prev ^ cur;
    end
    return r;
  endfunction : edge_hit

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Shared by the read and the write decode
  function automatic logic ofs_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : ofs_hit

  logic gie_reg;
  logic [19:0] en_reg;
  logic [19:0] prio_reg;
  logic [19:0] flag_reg;
  logic [19:0] flag_next;
  logic [5:0] extcfg_reg;
  logic [2:0] pin_prev_reg;
  logic resp_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [4:0] sel_idx_reg;
  logic sel_hi_reg;
  logic [15:0] vec_reg;
  logic svc_hi_reg;
  logic svc_lo_reg;
  logic [4:0] act_idx_reg;
  logic wake_reg;

  // Next values, one per register
  logic gie_next;
  logic [19:0] en_next;
  logic [19:0] prio_next;
  logic [5:0] extcfg_next;
  logic [2:0] pin_prev_next;
  logic resp_next;
  logic [31:0] rdata_next;
  logic irq_next;
  logic [4:0] sel_idx_next;
  logic sel_hi_next;
  logic [15:0] vec_next;
  logic svc_hi_next;
  logic svc_lo_next;
  logic [4:0] act_idx_next;
  logic wake_next;

  // Fixed one wait state on every access
  wire bus_req = avs_read_i | avs_write_i;
  wire wr_do = avs_write_i & resp_reg;
  wire [31:0] wmask = avs_writedata_i & lane_mask(avs_byteenable_i);
  wire [31:0] keep = ~lane_mask(avs_byteenable_i);
  wire wr_ctrl = wr_do & ofs_hit(avs_address_i, tsic_pkg::CTRL_OFS);
  wire wr_en = wr_do & ofs_hit(avs_address_i, tsic_pkg::ENABLE_OFS);
  wire wr_prio = wr_do & ofs_hit(avs_address_i, tsic_pkg::PRIO_OFS);
  wire wr_flag = wr_do & ofs_hit(avs_address_i, tsic_pkg::FLAG_OFS);
  wire wr_ext = wr_do & ofs_hit(avs_address_i, tsic_pkg::EXTCFG_OFS);

  // Pin edges, each pin with its own mode
  wire pin0_hit = edge_hit(extcfg_reg[1:0], pin_prev_reg[0], ext_pin_irq_i[0]);
  wire pin1_hit = edge_hit(extcfg_reg[3:2], pin_prev_reg[1], ext_pin_irq_i[1]);
  wire pin2_hit = edge_hit(extcfg_reg[5:4], pin_prev_reg[2], ext_pin_irq_i[2]);
  wire [2:0] ext_hit = {pin2_hit, pin1_hit, pin0_hit};
  wire [19:0] set_vec = (periph_req_i & ~tsic_pkg::EXT_SRC_MASK)
    | (20'(ext_hit[0]) << tsic_pkg::EXT0_IDX)
    | (20'(ext_hit[1]) << tsic_pkg::EXT1_IDX)
    | (20'(ext_hit[2]) << tsic_pkg::EXT2_IDX);

  // Gating: global, then per source
  wire [19:0] pend = flag_reg & en_reg & {20{gie_reg}};
  wire [5:0] hi_pick = first_set(pend & prio_reg);
  wire [5:0] lo_pick = first_set(pend & ~prio_reg);
  // High level in service blocks all; low in service admits only high
  wire take_hi = hi_pick[5] & ~svc_hi_reg;
  wire take_lo = lo_pick[5] & ~svc_hi_reg & ~svc_lo_reg & ~hi_pick[5];
  wire [4:0] cand_idx = take_hi ? hi_pick[4:0] : lo_pick[4:0];
  // Vector = base + 8 * polling index
  wire [15:0] cand_vec = tsic_pkg::VEC_BASE
    + (16'(cand_idx) << tsic_pkg::VEC_STEP_SHIFT);
  wire take_ack = cpu_ack_i & irq_reg;
  wire [19:0] ack_onehot = take_ack ? (20'h00001 << sel_idx_reg) : 20'h00000;
  wire [19:0] hw_clr = ack_onehot & tsic_pkg::HW_CLEAR_MASK;
  wire [19:0] sw_clr = wr_flag
    ? (wmask[19:0] & tsic_pkg::VISIBLE_MASK & ~tsic_pkg::HW_CLEAR_MASK) : 20'h00000;

  wire [31:0] status_word = {24'h000000, wake_reg, svc_hi_reg, svc_lo_reg, act_idx_reg};
  // One-hot read selects; an unmapped offset leaves the word at zero
  wire rd_ctrl = ofs_hit(avs_address_i, tsic_pkg::CTRL_OFS);
  wire rd_en = ofs_hit(avs_address_i, tsic_pkg::ENABLE_OFS);
  wire rd_prio = ofs_hit(avs_address_i, tsic_pkg::PRIO_OFS);
  wire rd_flag = ofs_hit(avs_address_i, tsic_pkg::FLAG_OFS);
  wire rd_ext = ofs_hit(avs_address_i, tsic_pkg::EXTCFG_OFS);
  wire rd_stat = ofs_hit(avs_address_i, tsic_pkg::STATUS_OFS);
  wire [31:0] rd_mux =
    ({32{rd_ctrl}} & {31'h00000000, gie_reg})
    | ({32{rd_en}} & {12'h000, en_reg})
    | ({32{rd_prio}} & {12'h000, prio_reg})
    | ({32{rd_flag}} & {12'h000, flag_reg & tsic_pkg::VISIBLE_MASK})
    | ({32{rd_ext}} & {26'h0000000, extcfg_reg})
    | ({32{rd_stat}} & status_word);

  // New events win over any clear in the same cycle
  assign flag_next = (flag_reg & ~sw_clr & ~hw_clr) | set_vec;

  assign avs_waitrequest_o = bus_req & ~resp_reg;
  assign avs_readdata_o = rdata_reg;
  assign cpu_irq_o = irq_reg;
  assign cpu_vector_o = vec_reg;
  assign stop_wake_o = wake_reg;

  // Read data is captured in the wait cycle, so it stands when waitrequest drops
  assign resp_next = bus_req & ~resp_reg;
  assign rdata_next = (avs_read_i & ~resp_reg)
    ? rd_mux
    : rdata_reg;

  // Register writes land only in the answer cycle
  assign gie_next = (wr_ctrl & avs_byteenable_i[0])
    ? avs_writedata_i[0]
    : gie_reg;
  assign en_next = wr_en
    ? ((en_reg & keep[19:0]) | wmask[19:0])
    : en_reg;
  assign prio_next = wr_prio
    ? ((prio_reg & keep[19:0]) | wmask[19:0])
    : prio_reg;
  assign extcfg_next = (wr_ext & avs_byteenable_i[0])
    ? avs_writedata_i[5:0]
    : extcfg_reg;
  assign pin_prev_next = ext_pin_irq_i;

  // Offer is dropped the cycle after an ack so one offer is taken once
  assign irq_next = (take_hi | take_lo) & ~cpu_ack_i;
  assign sel_idx_next = cand_idx;
  assign sel_hi_next = take_hi;
  assign vec_next = cand_vec;
  // Wake ignores the global enable so a masked core can still leave stop
  assign wake_next =
    |(flag_next & en_reg & tsic_pkg::WAKE_MASK);

  // In-service levels; an ack wins over a return in the same cycle
  assign act_idx_next = take_ack
    ? sel_idx_reg
    : act_idx_reg;
  assign svc_hi_next = take_ack
    ? (svc_hi_reg | sel_hi_reg)
    : (svc_hi_reg & ~cpu_reti_i);
  assign svc_lo_next = take_ack
    ? (svc_lo_reg | ~sel_hi_reg)
    : (svc_lo_reg & ~(cpu_reti_i & ~svc_hi_reg));

  // Bus side registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_reg <= 1'b0;
    end else begin
      resp_reg <= resp_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gie_reg <= tsic_pkg::CTRL_RST;
    end else begin
      gie_reg <= gie_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= tsic_pkg::ENABLE_RST;
    end else begin
      en_reg <= en_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_reg <= tsic_pkg::PRIO_RST;
    end else begin
      prio_reg <= prio_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      extcfg_reg <= tsic_pkg::EXTCFG_RST;
    end else begin
      extcfg_reg <= extcfg_next;
    end
  end

  // Request flags and pin history
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= tsic_pkg::FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Reset low: a pin already high at release looks like a rise, which the reset falling mode ignores
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev_reg <= 3'h0;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  // Offer registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_idx_reg <= 5'h00;
    end else begin
      sel_idx_reg <= sel_idx_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_hi_reg <= 1'b0;
    end else begin
      sel_hi_reg <= sel_hi_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_reg <= 16'h0000;
    end else begin
      vec_reg <= vec_next;
    end
  end

  // In-service registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      svc_hi_reg <= 1'b0;
    end else begin
      svc_hi_reg <= svc_hi_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      svc_lo_reg <= 1'b0;
    end else begin
      svc_lo_reg <= svc_lo_next;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_idx_reg <= 5'h00;
    end else begin
      act_idx_reg <= act_idx_next;
    end
  end

endmodule : tsic_controller
`default_nettype wire

// *** tsic_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsic_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic [2:0] delay_i,
  input wire logic reti_req_i,
  output logic ack_o,
  output logic reti_o
);
  logic [2:0] cnt_reg;
  wire logic wait_w = irq_i && !ack_o;
  // Takes the offer once it has stood delay_i + 1 cycles, to vary the latency
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 3'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= wait_w && (cnt_reg == delay_i);
      cnt_reg <= (wait_w && cnt_reg != delay_i) ? cnt_reg + 3'h1 : 3'h0;
    end
  end
  // Handler length is the bench's choice
  assign reti_o = reti_req_i;
endmodule : tsic_cpu_model
`default_nettype wire

// *** tsic_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsic_ctrl_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic cpu_ack_i,
  input wire logic cpu_irq_o,
  input wire logic [15:0] cpu_vector_o,
  input wire logic stop_wake_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_open;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_taken;
    cpu_ack_i && cpu_irq_o;
  endsequence
  chk_wait_one: assert property (s_open |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  chk_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait on first cycle");
  chk_idle_ready: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait without request");
  chk_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h14
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_ack_gap: assert property (s_taken |=> !cpu_irq_o)
    else $error("offer stayed after ack");
  chk_vec_form: assert property (cpu_irq_o |-> cpu_vector_o[2:0] == 3'h3 && cpu_vector_o <= 16'h009b)
    else $error("vector off table");
  chk_rst_quiet: assert property ($fell(rst_i) |-> !cpu_irq_o && !stop_wake_o)
    else $error("outputs active after reset");
endmodule : tsic_ctrl_sva
bind tsic_controller tsic_ctrl_sva u_sva (.*);
`default_nettype wire

// *** tsic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [19:0] periph_req_i = 20'h0;
  logic [2:0] ext_pin_irq_i = 3'h0;
  logic [2:0] delay = 3'h0;
  logic reti_req = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, cpu_ack_i, cpu_reti_i, cpu_irq_o, stop_wake_o;
  logic [15:0] cpu_vector_o;
  logic [31:0] rdat;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  tsic_controller uut (.*);
  tsic_cpu_model cpu (.clk_i(ref_clk_i), .rst_i(rst_i), .irq_i(cpu_irq_o), .delay_i(delay),
    .reti_req_i(reti_req), .ack_o(cpu_ack_i), .reti_o(cpu_reti_i));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic pulse(input logic [19:0] m);
    @(posedge ref_clk_i);
    periph_req_i <= m;
    @(posedge ref_clk_i);
    periph_req_i <= 20'h0;
  endtask : pulse
  // Vector is judged at the very edge the model acknowledges
  task automatic take(input logic [15:0] v);
    do @(posedge ref_clk_i); while (cpu_ack_i !== 1'b1);
    cmp({16'h0, cpu_vector_o}, {16'h0, v});
  endtask : take
  task automatic reti;
    @(posedge ref_clk_i);
    reti_req <= 1'b1;
    @(posedge ref_clk_i);
    reti_req <= 1'b0;
  endtask : reti
  task automatic quiet;
    repeat (8) begin
      @(posedge ref_clk_i);
      cmp({31'h0, cpu_irq_o}, 32'h0);
    end
  endtask : quiet
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      cmp(rdat, 32'h0);
    end
    bus(1'b1, tsic_pkg::ENABLE_OFS, 32'hfffff);
    pulse(20'h00002);
    quiet();
    bus(1'b1, tsic_pkg::CTRL_OFS, 32'h1);
    take(16'h000b);
    reti();
    $display("enable test done");
    for (int i = 1; i < 20; i++) begin
      if (i == 2 || i == 10) continue;
      delay <= 3'(i);
      pulse(20'h00001 << i);
      take(16'h0003 + 16'(8 * i));
      bus(1'b0, tsic_pkg::FLAG_OFS, 32'h0);
      cmp(rdat, (i inside {1, 3, 9, 11}) ? 32'h0 : 32'h1 << i);
      bus(1'b1, tsic_pkg::FLAG_OFS, 32'h1 << i);
      reti();
    end
    $display("vector test done");
    bus(1'b1, tsic_pkg::PRIO_OFS, 32'h01000);
    pulse(20'h00010);
    take(16'h0023);
    bus(1'b1, tsic_pkg::FLAG_OFS, 32'h10);
    pulse(20'h00020);
    quiet();
    pulse(20'h01000);
    take(16'h0063);
    bus(1'b0, tsic_pkg::STATUS_OFS, 32'h0);
    cmp(rdat, 32'h000000ec);
    bus(1'b1, tsic_pkg::FLAG_OFS, 32'h01000);
    reti();
    quiet();
    reti();
    take(16'h002b);
    bus(1'b1, tsic_pkg::FLAG_OFS, 32'h20);
    reti();
    pulse(20'h00048);
    take(16'h001b);
    reti();
    take(16'h0033);
    bus(1'b1, tsic_pkg::FLAG_OFS, 32'h40);
    reti();
    $display("priority test done");
    bus(1'b1, tsic_pkg::EXTCFG_OFS, 32'h21);
    ext_pin_irq_i <= 3'h7;
    take(16'h0003);
    reti();
    take(16'h0053);
    reti();
    quiet();
    ext_pin_irq_i <= 3'h0;
    take(16'h0013);
    reti();
    take(16'h0053);
    reti();
    bus(1'b0, tsic_pkg::FLAG_OFS, 32'h0);
    cmp(rdat, 32'h0);
    bus(1'b1, tsic_pkg::CTRL_OFS, 32'h0);
    pulse(20'h01000);
    @(posedge ref_clk_i);
    cmp({31'h0, stop_wake_o}, 32'h1);
    avs_byteenable_i <= 4'h2;
    bus(1'b1, tsic_pkg::ENABLE_OFS, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, tsic_pkg::ENABLE_OFS, 32'h0);
    cmp(rdat, 32'h000f00ff);
    $display("pin and wake test done");
    results();
  end
endmodule : testbench
`default_nettype wire
